// >>> inc/sacc_defs.vh
// Constants of the converter conversion control block
// What this block does
// - Resolve each sample to 16 bits, send MSB first on serial data.
// - Per trial from MSB: comparator low sets bit, high clears it.
// - Calibrate after power-up by averaged trials, about 14,000 clock cycles.
// - Reset pin low halts all; its rising edge restarts logic and calibrates.
// - Store one code per upper capacitor; apply it while that bit is high.
// - Range select: floating bipolar, high unipolar, low shutdown.
// - Convert-start low requests; further requests ignored until conversion ends.
// - Three cycles since last end: start next falling edge, end-flag after.
// - Fewer than three: start on fourth falling edge after previous end.
// - State kept while clock stops low; calibration survives shutdown.
// - Serial output driven only while chip-select is low, else released.
// - Read-during-conversion: each decided bit out on falling clock edges.
// - Between conversions MSB shows on chip-select fall; serial clocks shift.
// - After the LSB further serial clocks shift out zeros.
// - Output changes on falling serial clock edges; host samples later.
// - End-flag rises one cycle after start, falls one after end.
// - Serial clock may be fully asynchronous to the conversion clock.
`ifndef SACC_DEFS_VH
`define SACC_DEFS_VH

// ---------------------------------------------------------------
// Sizes and timing counts
// ---------------------------------------------------------------
`define SACC_RES_BITS 16
`define SACC_CAL_CYCLES 14000
`define SACC_ACQ_CYCLES 2'h3
`define SACC_UPPER_CAPS 10
`define SACC_CODE_BITS 8
`define SACC_CAL_AVG 64

// ---------------------------------------------------------------
// Control states
// ---------------------------------------------------------------
`define SACC_ST_HALT 2'h0
`define SACC_ST_CAL 2'h1
`define SACC_ST_IDLE 2'h2
`define SACC_ST_CONVERT_START_N 2'h3

`endif

// >>> hw/sacc_ctrl.v
// Conversion control of a 16-bit successive-approximation converter
`timescale 1ns/1ps
`include "sacc_defs.vh"

// ---------------------------------------------------------------
// Three-stage input sampler with agreement filter
// ---------------------------------------------------------------
module sacc_sync3 #(
  parameter INIT = 1'b0
) (
  input wire clk_sys,
  input wire reset,
  input wire din,
  output reg level
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end
endmodule // sacc_sync3

// ---------------------------------------------------------------
// Top of the control block
// ---------------------------------------------------------------
module sacc_ctrl #(
  parameter CAL_CYCLES = `SACC_CAL_CYCLES,
  parameter UPPER = `SACC_UPPER_CAPS,
  parameter CW = `SACC_CODE_BITS,
  parameter AVG = `SACC_CAL_AVG
) (
  input wire clk_sys,
  input wire reset,
  input wire convert_start_n_clk,
  input wire serial_clk,
  input wire convert_start_n,
  input wire chip_select_n,
  input wire adc_reset_n,
  input wire range_sel_high,
  input wire range_sel_low,
  input wire comparator_out,
  output reg eoc,
  output reg dout,
  output reg dout_oe,
  output reg range_unipolar,
  output reg range_bipolar,
  output reg shutdown,
  output reg cal_busy,
  output reg [15:0] dac_trial,
  output reg [UPPER-1:0] cal_dac_en,
  output reg [UPPER*CW-1:0] cal_codes
);
  wire cclk_lvl;
  wire sclk_lvl;
  wire convert_start_n_n_lvl;
  wire cs_n_lvl;
  wire rst_pin_lvl;
  wire rng_hi_lvl;
  wire rng_lo_lvl;
  wire comp_lvl;

  sacc_sync3 #(.INIT(1'b0)) u_cclk (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(convert_start_n_clk),
    .level(cclk_lvl)
  );
  sacc_sync3 #(.INIT(1'b0)) u_sclk (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(serial_clk),
    .level(sclk_lvl)
  );
  sacc_sync3 #(.INIT(1'b1)) u_convert_start_n (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(convert_start_n),
    .level(convert_start_n_n_lvl)
  );
  sacc_sync3 #(.INIT(1'b1)) u_cs (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(chip_select_n),
    .level(cs_n_lvl)
  );
  sacc_sync3 #(.INIT(1'b1)) u_rst (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(adc_reset_n),
    .level(rst_pin_lvl)
  );
  sacc_sync3 #(.INIT(1'b0)) u_rhi (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(range_sel_high),
    .level(rng_hi_lvl)
  );
  sacc_sync3 #(.INIT(1'b0)) u_rlo (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(range_sel_low),
    .level(rng_lo_lvl)
  );
  sacc_sync3 #(.INIT(1'b0)) u_cmp (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(comparator_out),
    .level(comp_lvl)
  );

  // ---------------------------------------------------------------
  // Edge detection on filtered levels
  // ---------------------------------------------------------------
  reg cclk_d;
  reg sclk_d;
  reg cs_n_d;
  reg rst_pin_d;
  wire cf = cclk_d & ~cclk_lvl;
  wire sclk_fall = sclk_d & ~sclk_lvl;
  wire cs_fall = cs_n_d & ~cs_n_lvl;
  wire rst_rise = ~rst_pin_d & rst_pin_lvl;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cclk_d <= 1'b0;
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      rst_pin_d <= 1'b1;
    end else begin
      cclk_d <= cclk_lvl;
      sclk_d <= sclk_lvl;
      cs_n_d <= cs_n_lvl;
      rst_pin_d <= rst_pin_lvl;
    end
  end

  // ---------------------------------------------------------------
  // Range and shutdown decode
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      range_unipolar <= 1'b0;
      range_bipolar <= 1'b1;
      shutdown <= 1'b0;
    end else begin
      shutdown <= rng_lo_lvl & ~rng_hi_lvl;
      range_unipolar <= rng_hi_lvl & ~rng_lo_lvl;
      range_bipolar <= ~rng_hi_lvl & ~rng_lo_lvl;
    end
  end

  // ---------------------------------------------------------------
  // Conversion and calibration sequencer
  // ---------------------------------------------------------------
  reg [1:0] state;
  reg [15:0] cal_cnt;
  reg [1:0] acq_cnt;
  reg pend;
  reg [3:0] bit_idx;
  reg [15:0] result;
  reg [15:0] sh;
  reg [3:0] cap_idx;
  reg [3:0] code_idx;
  reg [7:0] trial_cnt;
  reg [7:0] votes;
  reg cal_run;
  wire [7:0] next_votes = votes + {7'h00, ~comp_lvl};
  wire start_ok = pend & (acq_cnt == `SACC_ACQ_CYCLES) & ~shutdown;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= `SACC_ST_CAL;
      eoc <= 1'b0;
      cal_cnt <= 16'h0000;
      acq_cnt <= 2'h0;
      pend <= 1'b0;
      bit_idx <= 4'h0;
      result <= 16'h0000;
      sh <= 16'h0000;
      dac_trial <= 16'h0000;
      cal_codes <= {(UPPER*CW){1'b0}};
      cap_idx <= 4'h0;
      code_idx <= CW[3:0] - 4'h1;
      trial_cnt <= 8'h00;
      votes <= 8'h00;
      cal_run <= 1'b1;
      dout <= 1'b0;
    end else if (!rst_pin_lvl) begin
      state <= `SACC_ST_HALT;
      eoc <= 1'b0;
      pend <= 1'b0;
      dac_trial <= 16'h0000;
    end else if (rst_rise || state == `SACC_ST_HALT) begin
      state <= `SACC_ST_CAL;
      cal_cnt <= 16'h0000;
      acq_cnt <= 2'h0;
      pend <= 1'b0;
      cal_codes <= {(UPPER*CW){1'b0}};
      cap_idx <= 4'h0;
      code_idx <= CW[3:0] - 4'h1;
      trial_cnt <= 8'h00;
      votes <= 8'h00;
      cal_run <= 1'b1;
    end else begin
      // Serial readout between conversions
      if (state != `SACC_ST_CONVERT_START_N) begin
        if (cs_fall)
          sh <= result;
        else if (sclk_fall && !cs_n_lvl)
          sh <= {sh[14:0], 1'b0};
        // Last decided bit stands until the end-flag falls
        if (!eoc)
          dout <= sh[15];
      end
      // Requests are only latched once idle with end-flag low
      if (shutdown)
        pend <= 1'b0;
      else if (state == `SACC_ST_IDLE && !eoc && !convert_start_n_n_lvl)
        pend <= 1'b1;
      // No falling edge, no progress: a clock stopped low holds the sequencer; readout and request latching go on
      if (cf) begin
        eoc <= (state == `SACC_ST_CAL) || (state == `SACC_ST_CONVERT_START_N);
        case (state)
          `SACC_ST_CAL: begin
            cal_cnt <= cal_cnt + 16'h0001;
            if (cal_run) begin
              // Averaged trial of one code bit of one upper capacitor
              dac_trial <= 16'h8000 >> cap_idx;
              cal_codes[cap_idx*CW + code_idx] <= 1'b1;
              if (trial_cnt == AVG[7:0] - 8'h01) begin
                trial_cnt <= 8'h00;
                votes <= 8'h00;
                cal_codes[cap_idx*CW + code_idx] <=
                  (next_votes > (AVG[7:0] >> 1));
                if (code_idx != 4'h0) begin
                  code_idx <= code_idx - 4'h1;
                end else begin
                  code_idx <= CW[3:0] - 4'h1;
                  if (cap_idx == UPPER[3:0] - 4'h1)
                    cal_run <= 1'b0;
                  else
                    cap_idx <= cap_idx + 4'h1;
                end
              end else begin
                trial_cnt <= trial_cnt + 8'h01;
                votes <= next_votes;
              end
            end else begin
              dac_trial <= 16'h0000;
            end
            if (cal_cnt == CAL_CYCLES[15:0] - 16'h0001) begin
              state <= `SACC_ST_IDLE;
              acq_cnt <= 2'h0;
              dac_trial <= 16'h0000;
            end
          end
          `SACC_ST_IDLE: begin
            if (start_ok || (!convert_start_n_n_lvl && !eoc && !shutdown &&
                acq_cnt == `SACC_ACQ_CYCLES)) begin
              state <= `SACC_ST_CONVERT_START_N;
              pend <= 1'b0;
              bit_idx <= 4'hf;
              dac_trial <= 16'h8000;
            end else if (acq_cnt != `SACC_ACQ_CYCLES) begin
              acq_cnt <= acq_cnt + 2'h1;
            end
          end
          `SACC_ST_CONVERT_START_N: begin
            dac_trial[bit_idx] <= ~comp_lvl;
            result[bit_idx] <= ~comp_lvl;
            dout <= ~comp_lvl;
            if (bit_idx != 4'h0) begin
              dac_trial[bit_idx - 4'h1] <= 1'b1;
              bit_idx <= bit_idx - 4'h1;
            end else begin
              state <= `SACC_ST_IDLE;
              acq_cnt <= 2'h0;
              pend <= 1'b0;
              sh <= {result[15:1], ~comp_lvl};
            end
          end
          default: state <= `SACC_ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Output drive and correction enables
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dout_oe <= 1'b0;
      cal_dac_en <= {UPPER{1'b0}};
      cal_busy <= 1'b1;
    end else begin
      dout_oe <= ~cs_n_lvl;
      cal_dac_en <= dac_trial[15 -: UPPER];
      cal_busy <= (state == `SACC_ST_CAL);
    end
  end
endmodule // sacc_ctrl

// >>> sim/sacc_ctrl_asserts.sv
// Port checker of the conversion control block
`timescale 1ns/1ps
module sacc_ctrl_asserts #(
  parameter UPPER = 10
) (
  input wire clk_sys,
  input wire reset,
  input wire chip_select_n,
  input wire adc_reset_n,
  input wire range_sel_high,
  input wire range_sel_low,
  input wire eoc,
  input wire dout_oe,
  input wire range_unipolar,
  input wire range_bipolar,
  input wire shutdown,
  input wire cal_busy,
  input wire [15:0] dac_trial,
  input wire [UPPER-1:0] cal_dac_en
);
  wire [UPPER-1:0] upper_bits = dac_trial[15:16-UPPER];
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // ----------------
  // Port relations
  // ----------------
  a_oe_off: assert property (chip_select_n [*8] |-> !dout_oe)
    else $error("dout driven while deselected");
  a_oe_on: assert property (!chip_select_n [*8] |-> dout_oe)
    else $error("dout idle while selected");
  a_corr_dac: assert property (cal_dac_en == $past(upper_bits))
    else $error("correction enables off trial bits");
  a_range_off: assert property (
    (range_sel_low && !range_sel_high) [*8] |-> shutdown && !range_bipolar)
    else $error("shutdown not decoded");
  a_range_uni: assert property (
    (range_sel_high && !range_sel_low) [*8] |-> range_unipolar && !shutdown)
    else $error("unipolar not decoded");
  a_range_bip: assert property (
    (!range_sel_high && !range_sel_low) [*8] |-> range_bipolar && !shutdown)
    else $error("bipolar not decoded");
  a_halt_idle: assert property (
    !adc_reset_n [*8] |-> !eoc && dac_trial == 16'h0000)
    else $error("activity while halted");
  a_eoc_hold: assert property (
    $rose(eoc) |-> (eoc || !adc_reset_n) [*8])
    else $error("end flag pulse too short");
  c_cal: cover property ($fell(cal_busy));
  c_convert_start_n: cover property ($fell(eoc) && !cal_busy);
  c_read: cover property ($rose(dout_oe));
endmodule // sacc_ctrl_asserts

// >>> sim/sacc_cmp_model.sv
// Analog side model: comparator against a held input level
`timescale 1ns/1ps
module sacc_cmp_model (
  input wire [15:0] dac_trial,
  input wire [15:0] level,
  output wire comparator_out
);
  // High when the trial weight overshoots the input
  assign comparator_out = dac_trial > level;
endmodule // sacc_cmp_model

// >>> sim/sacc_ctrl_test.sv
// Self-checking bench of the conversion control block
`timescale 1ns/1ps
module sacc_ctrl_test;
  logic clk_sys = 0, reset = 1, convert_start_n_clk = 0, serial_clk = 0;
  logic convert_start_n = 1, chip_select_n = 1, adc_reset_n = 1;
  logic range_sel_high = 0, range_sel_low = 0, tie = 0, hi;
  logic [15:0] level = 16'h0000, got;
  logic [15:0] pats [3] = '{16'hffff, 16'h0000, 16'h4001};
  logic [79:0] saved;
  int fails = 0, checks_done = 0, cyc = 0, n;
  wire comparator_out, eoc, dout, dout_oe, cal_busy;
  wire range_unipolar, range_bipolar, shutdown;
  wire [15:0] dac_trial;
  wire [9:0] cal_dac_en;
  wire [79:0] cal_codes;
  wire start_n = tie ? eoc : convert_start_n;
  sacc_ctrl #(.CAL_CYCLES(400), .AVG(4)) dut_u (
    .clk_sys, .reset, .convert_start_n_clk, .serial_clk, .convert_start_n(start_n),
    .chip_select_n, .adc_reset_n, .range_sel_high, .range_sel_low,
    .comparator_out, .eoc, .dout, .dout_oe, .range_unipolar,
    .range_bipolar, .shutdown, .cal_busy, .dac_trial, .cal_dac_en,
    .cal_codes);
  sacc_cmp_model cm_u (.dac_trial, .level, .comparator_out);
  // ----------------
  // Clocks and tasks
  // ----------------
  initial forever #50 clk_sys = ~clk_sys;
  initial #137 forever #400 convert_start_n_clk = ~convert_start_n_clk;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end
  task tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [15:0] a, input logic [15:0] e);
    checks_done++;
    if (a !== e) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, a, e);
    end
  endtask
  task wait_eoc(input logic v);
    int j;
    for (j = 0; j < 9000 && eoc !== v; j++) tick(1);
    chk(eoc, v);
  endtask
  task convert(input logic [15:0] v);
    level = v;
    chip_select_n = 0;
    @(posedge convert_start_n_clk);
    tick(1);
    convert_start_n = 0;
    wait_eoc(1);
    convert_start_n = 1;
    repeat (16) begin
      @(negedge convert_start_n_clk);
      got = {got[14:0], dout};
    end
    wait_eoc(0);
    chk(got, v);
    chip_select_n = 1;
    tick(1);
  endtask
  task sread(input logic [15:0] v);
    tick(10);
    chk(dout_oe, 0);
    chip_select_n = 0;
    tick(10);
    for (n = 0; n < 18; n++) begin
      serial_clk = 1;
      tick(4);
      // Sampled late in the high phase, before the shifting fall
      if (n < 16) got = {got[14:0], dout};
      else chk(dout, 0);
      serial_clk = 0;
      tick(4);
    end
    chk(got, v);
    chip_select_n = 1;
    tick(10);
  endtask
  task gap(input int e);
    n = 0;
    do begin
      @(negedge convert_start_n_clk);
      n++;
    end while (eoc !== 1 && n < 40);
    chk(16'(n), 16'(e));
  endtask
  task rng(input logic h, input logic l, input logic [2:0] e);
    range_sel_high = h;
    range_sel_low = l;
    tick(10);
    chk({range_bipolar, range_unipolar, shutdown}, e);
  endtask
  task end_sim;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(16);
    reset = 0;
    wait_eoc(1);
    chk(cal_busy, 1);
    convert_start_n = 0;
    tick(40);
    convert_start_n = 1;
    wait_eoc(0);
    chk(cal_busy, 0);
    tick(80);
    chk(eoc, 0);
    convert(16'ha5c3);
    sread(16'ha5c3);
    sread(16'ha5c3);
    foreach (pats[k]) convert(pats[k]);
    tie = 1;
    wait_eoc(1);
    wait_eoc(0);
    gap(5);
    tick(1);
    tie = 0;
    wait_eoc(0);
    repeat (6) @(negedge convert_start_n_clk);
    @(posedge convert_start_n_clk);
    tick(1);
    convert_start_n = 0;
    gap(3);
    tick(1);
    convert_start_n = 1;
    wait_eoc(0);
    saved = cal_codes;
    rng(0, 1, 3'h1);
    convert_start_n = 0;
    hi = 0;
    repeat (200) begin
      tick(1);
      hi |= eoc;
    end
    chk(hi, 0);
    convert_start_n = 1;
    chk(16'(cal_codes !== saved), 0);
    rng(1, 0, 3'h2);
    rng(0, 0, 3'h4);
    convert(16'h1234);
    adc_reset_n = 0;
    tick(20);
    chk(eoc, 0);
    chk(dac_trial, 16'h0000);
    adc_reset_n = 1;
    wait_eoc(1);
    chk(cal_busy, 1);
    wait_eoc(0);
    convert(16'h7ffe);
    end_sim();
  end
endmodule // sacc_ctrl_test
bind sacc_ctrl sacc_ctrl_asserts #(.UPPER(UPPER)) chk_u (
  .clk_sys, .reset, .chip_select_n, .adc_reset_n, .range_sel_high,
  .range_sel_low, .eoc, .dout_oe, .range_unipolar, .range_bipolar,
  .shutdown, .cal_busy, .dac_trial, .cal_dac_en);
